// >>> design/cibt_top.sv
// Purpose: interrupt cause, status and bit timing registers over APB
// Assumes: message handler events arrive on CORE_CLK, rx pin is async
// Notes:   one wait state on every APB access
//
// How it works
// - cause register shows highest priority pending source, not oldest.
// - status first, then message objects, lower number wins.
// - object interrupt stays pending until its flag is cleared.
// - reading the status register clears the status interrupt.
// - identifier zero means nothing pending; nonzero means pending.
// - with line enable set, irq line follows any pending source.
// - identifier 0x8000 after a controller status write with status change enable set, or with error enable set on error.
// - writes clear rx ok, tx ok, error code; only read drops source.
// - status change enable gates status updates onto the interrupt.
// - identifier keeps updating while line enable is low.
// - transfer with clear-pending option clears the object's flag.
// - after clearing, identifier moves to next pending object.
// - bit rates from below 1 kbit/s up to the maximum rate.
// - bit is sync, propagation and two phase segments.
// - quantum is module clock divided by prescaler.
// - prescaler 1..64, first segment 1..16, second segment 1..8, jump width 1..4.
// - resync lengthens phase one or shortens phase two by at most jump width.
// - timing fields hold functional value minus one.
// - bit time is first plus second segment plus three quanta.
// - bit processing and sync decisions once per quantum.
// - processing time after sample point is zero quanta.
//
// The register addresses and register access over APB were decided locally.

`timescale 1ns/1ps
`default_nettype none

module cibt_top
  import cibt_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        NRST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // message handler events
  input  wire logic [31:0] OBJ_IRQ_SET,
  input  wire logic        STS_WRITE,
  input  wire logic        STS_ERR,
  input  wire logic [2:0]  STS_LEC,
  input  wire logic        STS_TRANSMIT_OK_FLAG,
  input  wire logic        STS_RECEIVE_OK_FLAG,
  output logic             XFER_REQ,
  output logic      [5:0]  XFER_OBJ,
  // can bus and cpu
  input  wire logic        CAN_RX,
  output logic             IRQ,
  output logic             TQ_TICK,
  output logic             BIT_START,
  output logic             SAMPLE_PULSE,
  output logic             RX_BIT
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic [3:0]  ctl;
    logic [2:0]  last_error_code;
    logic        transmit_ok_flag;
    logic        receive_ok_flag;
    logic        sts_pend;
    logic [14:0] bitr;
    logic        clrpnd;
    logic [5:0]  crq;
    logic [31:0] obj_pend;
    logic        xfer;
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
    logic        irq;
  } cibt_top_s;

  cibt_top_s st_q, st_d;

  logic [15:0] int_id;
  logic        setup_done;
  logic        commit;
  logic        wr_commit;
  logic        rd_commit;
  logic        mapped;
  logic [31:0] rd_value;
  logic [31:0] clr_mask;

  ////////////////////////////////////////////////////////////////////////////
  // submodules

  cibt_irq_prio #(
    .N_OBJ       (NUM_OBJ)
  ) u_prio (
    .status_pend (st_q.sts_pend),
    .obj_pend    (st_q.obj_pend),
    .int_id      (int_id)
  );

  cibt_bit_timing u_bt (
    .clk          (CORE_CLK),
    .rst_n        (NRST),
    .enable       (~st_q.ctl[CTL_INIT_BIT]),
    .quantum_prescaler          (st_q.bitr[BIT_BRP_LSB +: 6]),
    .resync_jump_width          (st_q.bitr[BIT_SJW_LSB +: 2]),
    .time_segment_before_sample        (st_q.bitr[BIT_TS1_LSB +: 4]),
    .time_segment_after_sample        (st_q.bitr[BIT_TS2_LSB +: 3]),
    .rx_pin       (CAN_RX),
    .tq_tick      (TQ_TICK),
    .bit_start    (BIT_START),
    .sample_pulse (SAMPLE_PULSE),
    .rx_bit       (RX_BIT)
  );

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  function automatic logic is_mapped(input logic [11:0] a);
    return (a == OFS_CTL) || (a == OFS_STS) || (a == OFS_BIT) ||
           (a == OFS_INT) || (a == OFS_CRQ) || (a == OFS_CMSK) ||
           (a == OFS_PND_LO) || (a == OFS_PND_HI);
  endfunction : is_mapped

  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (PADDR)
      OFS_CTL:    rd_value[3:0]  = st_q.ctl;
      OFS_STS: begin
        rd_value[STS_LEC_LSB +: 3] = st_q.last_error_code;
        rd_value[STS_TRANSMIT_OK_FLAG_BIT]     = st_q.transmit_ok_flag;
        rd_value[STS_RECEIVE_OK_FLAG_BIT]     = st_q.receive_ok_flag;
      end
      OFS_BIT:    rd_value[14:0] = st_q.bitr;
      OFS_INT:    rd_value[15:0] = int_id;
      OFS_CRQ:    rd_value[5:0]  = st_q.crq;
      OFS_CMSK:   rd_value[CMSK_CLRPND_BIT] = st_q.clrpnd;
      OFS_PND_LO: rd_value[15:0] = st_q.obj_pend[15:0];
      OFS_PND_HI: rd_value[15:0] = st_q.obj_pend[31:16];
      default:    rd_value = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d       = st_q;
    mapped     = is_mapped(PADDR);
    setup_done = PSEL & PENABLE & ~st_q.ready;
    commit     = PSEL & PENABLE & st_q.ready;
    wr_commit  = commit & PWRITE & mapped;
    rd_commit  = commit & ~PWRITE & mapped;
    clr_mask   = 32'h0000_0000;

    // apb: one wait state, data and error prepared before ready
    st_d.ready = setup_done;
    if (setup_done) begin
      st_d.rdata  = PWRITE ? 32'h0000_0000 : rd_value;
      st_d.slverr = ~mapped;
    end else if (commit) begin
      st_d.slverr = 1'b0;
    end

    // register writes take effect at the completing edge
    st_d.xfer = 1'b0;
    if (wr_commit) begin
      unique case (PADDR)
        OFS_CTL: st_d.ctl = PWDATA[3:0];
        OFS_STS: begin                              // write only clears
          if (!PWDATA[STS_TRANSMIT_OK_FLAG_BIT]) begin
            st_d.transmit_ok_flag = 1'b0;
          end
          if (!PWDATA[STS_RECEIVE_OK_FLAG_BIT]) begin
            st_d.receive_ok_flag = 1'b0;
          end
          st_d.last_error_code = st_q.last_error_code & PWDATA[STS_LEC_LSB +: 3];
        end
        OFS_BIT: begin
          if (st_q.ctl[CTL_INIT_BIT]) begin
            st_d.bitr = PWDATA[14:0];
          end
        end
        OFS_CMSK: st_d.clrpnd = PWDATA[CMSK_CLRPND_BIT];
        OFS_CRQ: begin
          if (PWDATA[5:0] >= 6'h01 && PWDATA[5:0] <= 6'(NUM_OBJ)) begin
            st_d.crq  = PWDATA[5:0];
            st_d.xfer = 1'b1;
            if (st_q.clrpnd) begin
              clr_mask = 32'h0000_0001 << (PWDATA[5:0] - 6'h01);
            end
          end
        end
        default: st_d.crq = st_q.crq;
      endcase
    end

    // status read drops the status source
    if (rd_commit && PADDR == OFS_STS) begin
      st_d.sts_pend = 1'b0;
    end

    // controller status update, set wins over the read clear
    if (STS_WRITE) begin
      st_d.last_error_code  = STS_LEC;
      st_d.transmit_ok_flag = st_d.transmit_ok_flag | STS_TRANSMIT_OK_FLAG;
      st_d.receive_ok_flag = st_d.receive_ok_flag | STS_RECEIVE_OK_FLAG;
      if (st_q.ctl[CTL_SIE_BIT] || (STS_ERR && st_q.ctl[CTL_EIE_BIT])) begin
        st_d.sts_pend = 1'b1;
      end
    end

    // object flags: held until cleared, new set wins
    st_d.obj_pend = (st_q.obj_pend & ~clr_mask) | OBJ_IRQ_SET;

    // line follows identifier, gated by enable
    st_d.irq = st_q.ctl[CTL_IE_BIT] && (int_id != ID_NONE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      st_q <= '{ctl: CTL_RST, bitr: BIT_RST, crq: CRQ_RST, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign PRDATA   = st_q.rdata;
  assign PREADY   = st_q.ready;
  assign PSLVERR  = st_q.slverr;
  assign IRQ      = st_q.irq;
  assign XFER_REQ = st_q.xfer;
  assign XFER_OBJ = st_q.crq;

endmodule : cibt_top

`default_nettype wire

// >>> design/cibt_pkg.sv
// Purpose: shared constants for the interrupt and bit timing block
// Assumes: 32-bit APB register words, offsets are byte addresses
// Notes:   reset values and field positions live here only

package cibt_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_CTL    = 12'h000;
  localparam logic [11:0] OFS_STS    = 12'h004;
  localparam logic [11:0] OFS_BIT    = 12'h00C;
  localparam logic [11:0] OFS_INT    = 12'h010;
  localparam logic [11:0] OFS_CRQ    = 12'h020;
  localparam logic [11:0] OFS_CMSK   = 12'h024;
  localparam logic [11:0] OFS_PND_LO = 12'h140;
  localparam logic [11:0] OFS_PND_HI = 12'h144;

  // reset values
  localparam logic [3:0]  CTL_RST    = 4'h1;
  localparam logic [14:0] BIT_RST    = 15'h2301;
  localparam logic [5:0]  CRQ_RST    = 6'h01;

  // controller_control_register fields
  localparam int CTL_INIT_BIT = 0;
  localparam int CTL_IE_BIT   = 1;
  localparam int CTL_SIE_BIT  = 2;
  localparam int CTL_EIE_BIT  = 3;

  // controller_status_register fields
  localparam int STS_LEC_LSB  = 0;
  localparam int STS_TRANSMIT_OK_FLAG_BIT = 3;
  localparam int STS_RECEIVE_OK_FLAG_BIT = 4;

  // bit_timing_register fields
  localparam int BIT_BRP_LSB  = 0;
  localparam int BIT_SJW_LSB  = 6;
  localparam int BIT_TS1_LSB  = 8;
  localparam int BIT_TS2_LSB  = 12;

  // interface_command_mask fields
  localparam int CMSK_CLRPND_BIT = 3;

  // interrupt identifier codes
  localparam logic [15:0] ID_NONE   = 16'h0000;
  localparam logic [15:0] ID_STATUS = 16'h8000;

  localparam int NUM_OBJ = 32;

  typedef enum logic [1:0] {
    SEG_SYNC,
    SEG_ONE,
    SEG_TWO
  } cibt_seg_e;

endpackage : cibt_pkg

// >>> design/cibt_irq_prio.sv
// Purpose: picks the highest priority pending interrupt
// Assumes: object 1 sits at bit 0 of the pending map
// Notes:   purely combinational, no state

`timescale 1ns/1ps
`default_nettype none

module cibt_irq_prio
  import cibt_pkg::*;
#(
  parameter int N_OBJ = NUM_OBJ
) (
  input  wire logic              status_pend,
  input  wire logic [N_OBJ-1:0]  obj_pend,
  output logic      [15:0]       int_id
);

  // lowest object number wins, coded as number (index plus one)
  function automatic logic [15:0] first_obj(input logic [N_OBJ-1:0] p);
    logic [15:0] r;
    r = ID_NONE;
    for (int i = N_OBJ - 1; i >= 0; i--) begin
      if (p[i]) begin
        r = 16'(i + 1);
      end
    end
    return r;
  endfunction : first_obj

  always_comb begin
    if (status_pend) begin
      int_id = ID_STATUS;
    end else begin
      int_id = first_obj(obj_pend);
    end
  end

endmodule : cibt_irq_prio

`default_nettype wire

// >>> design/cibt_bit_timing.sv
// Purpose: quantum prescaler and bit time segment sequencer
// Assumes: rx pin is asynchronous, dominant is low
// Notes:   all decisions are taken on the quantum tick

`timescale 1ns/1ps
`default_nettype none

module cibt_bit_timing
  import cibt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        enable,
  input  wire logic [5:0]  quantum_prescaler,
  input  wire logic [1:0]  resync_jump_width,
  input  wire logic [3:0]  time_segment_before_sample,
  input  wire logic [2:0]  time_segment_after_sample,
  input  wire logic        rx_pin,
  output logic             tq_tick,
  output logic             bit_start,
  output logic             sample_pulse,
  output logic             rx_bit
);

  typedef struct packed {
    logic       rx_m;
    logic       rx_s;
    logic       rx_prev;
    logic [5:0] pre;
    logic       tick;
    logic       edge_seen;
    cibt_seg_e  seg;
    logic [4:0] cnt;
    logic [4:0] len;
    logic       bstart;
    logic       sample;
    logic       bitv;
  } cibt_bt_s;

  cibt_bt_s st_q, st_d;

  logic       edge_now;
  logic       edge_any;
  logic       quantum;
  logic [4:0] jump;
  logic [4:0] rem;

  always_comb begin
    st_d        = st_q;
    st_d.rx_m   = rx_pin;
    st_d.rx_s   = st_q.rx_m;
    st_d.rx_prev = st_q.rx_s;
    edge_now    = st_q.rx_prev & ~st_q.rx_s;
    quantum     = enable && (st_q.pre == quantum_prescaler);
    edge_any    = st_q.edge_seen | edge_now;
    jump        = 5'(resync_jump_width) + 5'h01;
    rem         = st_q.len - st_q.cnt;
    st_d.tick   = quantum;
    st_d.bstart = 1'b0;
    st_d.sample = 1'b0;
    st_d.edge_seen = edge_now | (st_q.edge_seen & ~quantum);
    st_d.pre    = quantum ? 6'h00 : st_q.pre + 6'h01;
    if (!enable) begin
      st_d.pre  = 6'h00;
      st_d.seg  = SEG_SYNC;
      st_d.cnt  = 5'h00;
    end else if (quantum) begin
      unique case (st_q.seg)
        SEG_SYNC: begin                           // one quantum
          st_d.seg    = SEG_ONE;
          st_d.cnt    = 5'h00;
          st_d.len    = 5'(time_segment_before_sample) + 5'h01;
          st_d.bstart = 1'b1;
        end
        SEG_ONE: begin
          if (edge_any) begin                     // lengthen
            st_d.len = st_q.len + ((st_q.cnt + 5'h01 < jump) ? st_q.cnt + 5'h01 : jump);
          end
          if (!edge_any && st_q.cnt + 5'h01 >= st_q.len) begin
            st_d.seg    = SEG_TWO;                // no extra quanta
            st_d.cnt    = 5'h00;
            st_d.len    = 5'(time_segment_after_sample) + 5'h01;
            st_d.sample = 1'b1;
            st_d.bitv   = st_q.rx_s;
          end else begin
            st_d.cnt = st_q.cnt + 5'h01;
          end
        end
        SEG_TWO: begin
          if (edge_any && rem <= jump) begin      // shorten
            st_d.seg    = SEG_ONE;
            st_d.cnt    = 5'h00;
            st_d.len    = 5'(time_segment_before_sample) + 5'h01;
            st_d.bstart = 1'b1;
          end else if (st_q.cnt + 5'h01 >= (edge_any ? st_q.len - jump : st_q.len)) begin
            st_d.seg = SEG_SYNC;
            st_d.cnt = 5'h00;
          end else begin
            st_d.cnt = st_q.cnt + 5'h01;
            if (edge_any) begin
              st_d.len = st_q.len - jump;
            end
          end
        end
        default: st_d.seg = SEG_SYNC;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{rx_m: 1'b1, rx_s: 1'b1, rx_prev: 1'b1, seg: SEG_SYNC, bitv: 1'b1, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign tq_tick      = st_q.tick;
  assign bit_start    = st_q.bstart;
  assign sample_pulse = st_q.sample;
  assign rx_bit       = st_q.bitv;

endmodule : cibt_bit_timing

`default_nettype wire

// >>> tb/cibt_top_properties.sv
// Purpose: port level checks for cibt_top
// Assumes: ctl and prescaler mirrored from apb traffic, status source from status writes and status reads
// Notes:   bound from tb_top
`timescale 1ns/1ps
`default_nettype none
module cibt_chk
  import cibt_pkg::*;
(
  input wire logic        CORE_CLK,
  input wire logic        NRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [31:0] OBJ_IRQ_SET,
  input wire logic        STS_WRITE,
  input wire logic        STS_ERR,
  input wire logic        XFER_REQ,
  input wire logic        IRQ,
  input wire logic        TQ_TICK,
  input wire logic        BIT_START,
  input wire logic        SAMPLE_PULSE
);
  ////////////////////////////////////////////////////////////////////////////
  logic       done, wr, rd_int;
  logic [3:0] ctl_q;
  logic [5:0] brp_q, cnt_q;
  logic       seen_q, st_q;
  assign done   = PSEL && PENABLE && PREADY;
  assign wr     = done && PWRITE;
  assign rd_int = done && !PWRITE && PADDR == OFS_INT;
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      ctl_q  <= CTL_RST;
      brp_q  <= BIT_RST[5:0];
      cnt_q  <= 6'h00;
      seen_q <= 1'b0;
      st_q   <= 1'b0;
    end else begin
      if (wr && PADDR == OFS_CTL) ctl_q <= PWDATA[3:0];
      if (wr && PADDR == OFS_BIT && ctl_q[CTL_INIT_BIT]) brp_q <= PWDATA[5:0];
      cnt_q  <= TQ_TICK ? 6'h00 : cnt_q + 6'h01;
      seen_q <= !wr && (seen_q || TQ_TICK);
      // hardware set wins over the clearing read
      if (STS_WRITE && (ctl_q[CTL_SIE_BIT] || (STS_ERR && ctl_q[CTL_EIE_BIT]))) st_q <= 1'b1;
      else if (done && !PWRITE && PADDR == OFS_STS) st_q <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  AST_APB_WAIT: assert property (PSEL && !PENABLE |-> ##2 PREADY)
    else $error("pready late");
  AST_APB_ONE: assert property (PREADY |=> !PREADY)
    else $error("pready longer than one cycle");
  AST_APB_ERR: assert property (PSLVERR |-> PREADY)
    else $error("pslverr without pready");
  AST_IRQ_SET: assert property (ctl_q[CTL_IE_BIT] && OBJ_IRQ_SET != 32'h0
    && !(wr && PADDR == OFS_CTL) |-> ##2 IRQ)
    else $error("irq not raised");
  AST_IRQ_OFF: assert property (!ctl_q[CTL_IE_BIT] |=> !IRQ)
    else $error("irq while line disabled");
  AST_STS_ID: assert property (rd_int |-> (PRDATA[15:0] == ID_STATUS) == $past(st_q))
    else $error("status identifier wrong");
  AST_ID_HI: assert property (rd_int |-> PRDATA[31:16] == 16'h0000 &&
    IRQ == (ctl_q[CTL_IE_BIT] && PRDATA[15:0] != ID_NONE))
    else $error("identifier upper bits set");
  AST_TQ_LEN: assert property (TQ_TICK && seen_q |-> cnt_q == brp_q)
    else $error("quantum length wrong");
  AST_SEG: assert property (!(BIT_START && SAMPLE_PULSE))
    else $error("sample in sync segment");
  AST_XFER: assert property (wr && PADDR == OFS_CRQ && PWDATA[5:0] == 6'h01 |-> ##[1:2] XFER_REQ)
    else $error("no transfer request");
  cover property (IRQ ##1 !IRQ);
  cover property (rd_int && PRDATA[15:0] == ID_STATUS);
  cover property (SAMPLE_PULSE);
endmodule : cibt_chk
`default_nettype wire

// >>> tb/cibt_far_node.sv
// Purpose: another node on the bus sending one byte of bits
// Assumes: bit length in module clocks given by the bench
// Notes:   idle level recessive, pin driven high after the last bit sent
`timescale 1ns/1ps
`default_nettype none
module cibt_far_node (
  input  wire logic        clk,
  input  wire logic        send,
  input  wire logic [7:0]  bits,
  input  wire logic [15:0] bit_clks,
  output var  logic        can_rx,
  output var  logic        busy
);
  initial begin
    can_rx = 1'b1;
    busy   = 1'b0;
  end
  always begin
    @(posedge clk);
    if (send) begin
      busy <= 1'b1;
      for (int i = 7; i >= 0; i--) begin
        can_rx <= bits[i];
        repeat (bit_clks) @(posedge clk);
      end
      can_rx <= 1'b1;
      busy   <= 1'b0;
    end
  end
endmodule : cibt_far_node
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: self checking bench for cibt_top
// Assumes: one wait state apb slave
// Notes:   far node drives the bus pin
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import cibt_pkg::*;
;
  logic        CORE_CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
  logic        STS_WRITE, STS_ERR, STS_TRANSMIT_OK_FLAG, STS_RECEIVE_OK_FLAG, XFER_REQ, CAN_RX, send, busy;
  logic        TQ_TICK, BIT_START, SAMPLE_PULSE, RX_BIT;
  logic [2:0]  STS_LEC;
  logic [5:0]  XFER_OBJ;
  logic [7:0]  fbits;
  logic [11:0] PADDR;
  logic [15:0] fclks;
  logic [31:0] PWDATA, PRDATA, OBJ_IRQ_SET;
  int          miscompares, checks_done, cycles;
  cibt_top uut (.CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .OBJ_IRQ_SET(OBJ_IRQ_SET), .STS_WRITE(STS_WRITE), .STS_ERR(STS_ERR),
    .STS_LEC(STS_LEC), .STS_TRANSMIT_OK_FLAG(STS_TRANSMIT_OK_FLAG), .STS_RECEIVE_OK_FLAG(STS_RECEIVE_OK_FLAG), .XFER_REQ(XFER_REQ),
    .XFER_OBJ(XFER_OBJ), .CAN_RX(CAN_RX), .IRQ(IRQ), .TQ_TICK(TQ_TICK),
    .BIT_START(BIT_START), .SAMPLE_PULSE(SAMPLE_PULSE), .RX_BIT(RX_BIT));
  cibt_far_node u_far (.clk(CORE_CLK), .send(send), .bits(fbits), .bit_clks(fclks),
    .can_rx(CAN_RX), .busy(busy));
  always #5 CORE_CLK = ~CORE_CLK;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] x, input string m);
    checks_done++;
    if (got !== x) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1, "apb hang");
    q = PRDATA;
    e = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rdchk(input logic [11:0] a, input logic [31:0] x, input string m);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x, m);
  endtask : rdchk
  // s = {write, err, transmit_ok_flag, receive_ok_flag, lec}
  task automatic ev(input logic [31:0] m, input logic [6:0] s);
    OBJ_IRQ_SET <= m;
    {STS_WRITE, STS_ERR, STS_TRANSMIT_OK_FLAG, STS_RECEIVE_OK_FLAG, STS_LEC} <= s;
    @(posedge CORE_CLK);
    OBJ_IRQ_SET <= 32'h0;
    {STS_WRITE, STS_ERR, STS_TRANSMIT_OK_FLAG, STS_RECEIVE_OK_FLAG, STS_LEC} <= 7'h00;
    @(posedge CORE_CLK);
  endtask : ev
  task automatic wait_ev(input logic smp, output int n);
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while ((smp ? SAMPLE_PULSE : BIT_START) !== 1'b1 && n < 3000);
    if (n >= 3000) chk(32'h0, 32'h1, "event timeout");
  endtask : wait_ev
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    rdchk(OFS_CTL, 32'h1, "ctl reset");
    rdchk(OFS_BIT, 32'h2301, "bit reset");
    rdchk(OFS_INT, 32'h0, "int reset");
    rdchk(OFS_CRQ, 32'h1, "crq reset");
    apb(1'b0, 12'h0FC, 32'h0, q, e);
    chk({31'h0, e}, 32'h1, "unmapped err");
    chk(q, 32'h0, "unmapped data");
    $display("regs done");
  endtask : t_regs
  task automatic t_prio;
    wr(OFS_CTL, 32'h5);
    ev(32'h10, 7'h00);
    ev(32'h02, 7'h00);
    rdchk(OFS_INT, 32'h2, "lowest object wins");
    rdchk(OFS_PND_LO, 32'h12, "pending map");
    ev(32'h0, 7'h40);
    rdchk(OFS_INT, 32'h8000, "status first");
    rdchk(OFS_STS, 32'h0, "status value");
    rdchk(OFS_INT, 32'h2, "status read clears");
    wr(OFS_CMSK, 32'h8);
    wr(OFS_CRQ, 32'h2);
    chk({26'h0, XFER_OBJ}, 32'h2, "xfer object");
    rdchk(OFS_INT, 32'h5, "next pending");
    wr(OFS_CMSK, 32'h0);
    wr(OFS_CRQ, 32'h5);
    rdchk(OFS_INT, 32'h5, "kept without option");
    wr(OFS_CMSK, 32'h8);
    wr(OFS_CRQ, 32'h5);
    rdchk(OFS_INT, 32'h0, "all clear");
    ev(32'h8000_0000, 7'h00);
    rdchk(OFS_PND_HI, 32'h8000, "pending map high");
    rdchk(OFS_INT, 32'h20, "last object");
    wr(OFS_CRQ, 32'h20);
    wr(OFS_CRQ, 32'h21);
    chk({26'h0, XFER_OBJ}, 32'h20, "object out of range");
    rdchk(OFS_INT, 32'h0, "last object cleared");
    $display("prio done");
  endtask : t_prio
  task automatic t_irq;
    wr(OFS_CTL, 32'h3);
    ev(32'h0, 7'h58);
    rdchk(OFS_INT, 32'h0, "status gated");
    rdchk(OFS_STS, 32'h18, "ok flags");
    wr(OFS_STS, 32'h0);
    rdchk(OFS_STS, 32'h0, "write clears ok");
    wr(OFS_CTL, 32'hB);
    ev(32'h0, 7'h65);
    wr(OFS_STS, 32'h0);
    rdchk(OFS_INT, 32'h8000, "write keeps source");
    chk({31'h0, IRQ}, 32'h1, "irq on error");
    rdchk(OFS_STS, 32'h0, "lec cleared");
    rdchk(OFS_INT, 32'h0, "read drops source");
    chk({31'h0, IRQ}, 32'h0, "irq dropped");
    ev(32'h1, 7'h00);
    rdchk(OFS_INT, 32'h1, "object one");
    chk({31'h0, IRQ}, 32'h1, "irq on object");
    wr(OFS_CTL, 32'h9);
    rdchk(OFS_INT, 32'h1, "id with line off");
    chk({31'h0, IRQ}, 32'h0, "irq line off");
    wr(OFS_CMSK, 32'h8);
    wr(OFS_CRQ, 32'h1);
    $display("irq done");
  endtask : t_irq
  task automatic t_bit;
    logic [31:0] cfg [2];
    int          n, x;
    cfg[0] = 32'h1201;
    cfg[1] = 32'h7FDF;
    for (int i = 0; i < 2; i++) begin
      x = (cfg[i][5:0] + 1) * (cfg[i][11:8] + cfg[i][14:12] + 3);
      wr(OFS_CTL, 32'h1);
      wr(OFS_BIT, cfg[i]);
      rdchk(OFS_BIT, cfg[i], "bit config");
      wr(OFS_CTL, 32'h0);
      wr(OFS_BIT, 32'h0);
      rdchk(OFS_BIT, cfg[i], "bit write while running");
      wait_ev(1'b0, n);
      wait_ev(1'b0, n);
      chk(n, x, "bit length");
    end
    fbits <= 8'h00;
    fclks <= x[15:0];
    send  <= 1'b1;
    @(posedge CORE_CLK);
    send <= 1'b0;
    repeat (3 * x) @(posedge CORE_CLK);
    wait_ev(1'b1, n);
    @(posedge CORE_CLK);
    chk({31'h0, RX_BIT}, 32'h0, "dominant sampled");
    while (busy) @(posedge CORE_CLK);
    repeat (2 * x) @(posedge CORE_CLK);
    wait_ev(1'b1, n);
    @(posedge CORE_CLK);
    chk({31'h0, RX_BIT}, 32'h1, "recessive sampled");
    $display("bit done");
  endtask : t_bit
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge CORE_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 25000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    {CORE_CLK, NRST, PSEL, PENABLE, PWRITE, send} = 6'h00;
    {STS_WRITE, STS_ERR, STS_TRANSMIT_OK_FLAG, STS_RECEIVE_OK_FLAG, STS_LEC} = 7'h00;
    {PADDR, PWDATA, OBJ_IRQ_SET, fbits, fclks} = '0;
    {miscompares, checks_done, cycles} = '0;
    repeat (5) @(posedge CORE_CLK);
    NRST <= 1'b1;
    @(posedge CORE_CLK);
    t_regs();
    t_prio();
    t_irq();
    t_bit();
    wrap_up();
  end
endmodule : tb_top
bind cibt_top cibt_chk u_chk (.CORE_CLK(CORE_CLK), .NRST(NRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .OBJ_IRQ_SET(OBJ_IRQ_SET), .STS_WRITE(STS_WRITE),
  .STS_ERR(STS_ERR), .XFER_REQ(XFER_REQ), .IRQ(IRQ), .TQ_TICK(TQ_TICK),
  .BIT_START(BIT_START), .SAMPLE_PULSE(SAMPLE_PULSE));
`default_nettype wire
